// file: design/hlt_timer.sv
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module hlt_timer (
    input wire logic core_clk,
    input wire logic srst,
    input wire hlt_pkg::hlt_apb_req_s apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extResetInput,
    output logic [7:0] countValue,
    output logic periodMatch,
    output logic pwmOut
);
    logic [7:0] count_q;
    logic [7:0] period_q;
    logic [7:0] width_q;
    logic [4:0] mode_q;
    logic run_q;
    logic runDelay_q;
    logic extPrev_q;
    logic pwm_q;
    logic [1:0] restart_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic periodMatch_q;
    hlt_pkg::hlt_state_e state_q;
    hlt_pkg::hlt_state_e state_d;
    logic [7:0] count_d;
    logic run_d;
    logic pwm_d;
    logic [1:0] restart_d;
    logic extSync;

    // The external input is asynchronous, so it is filtered before any decision uses it.
    hlt_sync u_ext_sync (
        .core_clk(core_clk),
        .srst(srst),
        .asyncIn(extResetInput),
        .syncOut(extSync)
    ); // [R21]

    function automatic logic isMode(input logic [4:0] m, input logic [4:0] ref_m);
        isMode = (m == ref_m);
    endfunction : isMode

    // APB decode. Three-cycle access: setup, then access phase with one wait state before pready high.
    wire apbAccess = apbReq.psel && apbReq.penable;
    wire apbWrite = apbAccess && apbReq.pwrite && pready_q;
    wire hitCount = apbReq.paddr == hlt_pkg::ADDR_COUNT;
    wire hitPeriod = apbReq.paddr == hlt_pkg::ADDR_PERIOD;
    wire hitWidth = apbReq.paddr == hlt_pkg::ADDR_WIDTH;
    wire hitCtrl = apbReq.paddr == hlt_pkg::ADDR_CTRL;
    wire hitStatus = apbReq.paddr == hlt_pkg::ADDR_STATUS;
    wire hitAny = hitCount || hitPeriod || hitWidth || hitCtrl || hitStatus;
    wire wrCount = apbWrite && hitCount;
    wire wrCtrl = apbWrite && hitCtrl;
    wire [31:0] readMux = hitCount ? {24'h000000, count_q} :
        hitPeriod ? {24'h000000, period_q} :
        hitWidth ? {24'h000000, width_q} :
        hitCtrl ? {19'h00000, mode_q, 7'h00, run_q} :
        hitStatus ? {29'h00000000, pwm_q, extSync, periodMatch_q} : 32'h0000_0000;

    // Run bit applies two clocks after software writes it.
    wire runEff = runDelay_q; // [R21]
    // The delayed copy lags a hardware clear, so a start also needs the live bit or a one-shot would retrigger.
    wire runStart = runEff && run_q; // [R11] [R19]

    // Edges compare successive synchronised samples.
    wire riseEdge = extSync && !extPrev_q; // [R23]
    wire fallEdge = !extSync && extPrev_q; // [R23]
    wire anyEdge = riseEdge || fallEdge;
    wire atPeriod = count_q == period_q;
    wire atWidth = count_q == width_q;

    wire mGateSw = isMode(mode_q, hlt_pkg::MODE_SW_GATE);
    wire mGateHi = isMode(mode_q, hlt_pkg::MODE_GATE_HIGH_STOP);
    wire mGateLo = isMode(mode_q, hlt_pkg::MODE_GATE_LOW_STOP);
    wire mEdgeRst = isMode(mode_q, hlt_pkg::MODE_EDGE_RST_ANY) ||
        isMode(mode_q, hlt_pkg::MODE_EDGE_RST_RISE) || isMode(mode_q, hlt_pkg::MODE_EDGE_RST_FALL);
    wire mLevel = isMode(mode_q, hlt_pkg::MODE_LEVEL_RST_LOW) || isMode(mode_q, hlt_pkg::MODE_LEVEL_RST_HIGH);
    wire mOneSw = isMode(mode_q, hlt_pkg::MODE_ONESHOT_SW);
    wire mOneEdge = isMode(mode_q, hlt_pkg::MODE_ONESHOT_RISE) ||
        isMode(mode_q, hlt_pkg::MODE_ONESHOT_FALL) || isMode(mode_q, hlt_pkg::MODE_ONESHOT_ANY);
    wire mLimit = isMode(mode_q, hlt_pkg::MODE_LIMIT_ONESHOT_RISE) ||
        isMode(mode_q, hlt_pkg::MODE_LIMIT_ONESHOT_FALL);

    // Selected edge per mode.
    wire rstEdge = isMode(mode_q, hlt_pkg::MODE_EDGE_RST_ANY) ? anyEdge :
        isMode(mode_q, hlt_pkg::MODE_EDGE_RST_RISE) ? riseEdge : fallEdge; // [R5]
    wire startEdge = isMode(mode_q, hlt_pkg::MODE_ONESHOT_RISE) ? riseEdge :
        isMode(mode_q, hlt_pkg::MODE_ONESHOT_FALL) ? fallEdge : anyEdge; // [R14]
    wire limitEdge = isMode(mode_q, hlt_pkg::MODE_LIMIT_ONESHOT_RISE) ? riseEdge : fallEdge; // [R17]

    // Level reset active level; ignored while the run bit is clear.
    wire levelActive = isMode(mode_q, hlt_pkg::MODE_LEVEL_RST_HIGH) ? extSync : !extSync; // [R7]
    wire levelReset = mLevel && runEff && levelActive; // [R8]

    // Hardware gate halts counting at the selected level.
    wire gateOpen = mGateHi ? !extSync : mGateLo ? extSync : 1'b1; // [R3]

    // Gate, edge-reset, level-reset and software one-shot modes count straight from the run bit.
    wire freeRun = mGateSw || mGateHi || mGateLo || mEdgeRst || mLevel || mOneSw;
    wire oneShot = mOneSw || mOneEdge || mLimit;

    always_comb
    begin
        state_d = state_q;
        count_d = count_q;
        run_d = run_q;
        pwm_d = pwm_q;
        restart_d = restart_q;
        if (restart_q != 2'h0)
            restart_d = restart_q - 2'h1;
        case (state_q)
            hlt_pkg::ST_IDLE:
            begin
                // Waiting for a start condition; edge one-shot and edge-limit modes need a fresh edge here.
                if (runStart && freeRun && !levelReset)
                begin
                    state_d = hlt_pkg::ST_RUN;
                    pwm_d = 1'b1; // [R13]
                end
                else if (runStart && mOneEdge && startEdge)
                begin
                    state_d = hlt_pkg::ST_RUN;
                    pwm_d = 1'b1; // [R16]
                end
                else if (runStart && mLimit && limitEdge)
                begin
                    state_d = hlt_pkg::ST_RUN;
                    pwm_d = 1'b1; // [R20]
                end
            end
            hlt_pkg::ST_RUN:
            begin
                if (!runEff)
                begin
                    // Pausing keeps pwm as is, so the drive is stretched by the pause.
                    state_d = (mOneEdge || mLimit) ? hlt_pkg::ST_IDLE : hlt_pkg::ST_HOLD; // [R12] [R15] [R4]
                end
                else if (levelReset)
                begin
                    count_d = hlt_pkg::COUNT_RESET; // [R9]
                    state_d = hlt_pkg::ST_HOLD; // [R10]
                end
                else if (mEdgeRst && rstEdge)
                begin
                    count_d = hlt_pkg::COUNT_RESET; // [R5]
                    restart_d = hlt_pkg::RESTART_DELAY; // [R6]
                    state_d = hlt_pkg::ST_HOLD;
                end
                else if (mLimit && limitEdge)
                begin
                    count_d = hlt_pkg::COUNT_RESET; // [R17]
                    restart_d = hlt_pkg::RESTART_DELAY; // [R18]
                    pwm_d = 1'b1; // [R20]
                    state_d = hlt_pkg::ST_HOLD;
                end
                else if (gateOpen)
                begin
                    if (atPeriod)
                    begin
                        count_d = hlt_pkg::COUNT_RESET; // [R2]
                        if (oneShot)
                        begin
                            run_d = 1'b0; // [R11] [R19]
                            pwm_d = 1'b0; // [R16]
                            state_d = hlt_pkg::ST_IDLE;
                        end
                        else
                            pwm_d = 1'b1;
                    end
                    else
                    begin
                        count_d = count_q + 8'h01; // [R1]
                        if (atWidth)
                            pwm_d = 1'b0;
                    end
                end
            end
            hlt_pkg::ST_HOLD:
            begin
                // Restart after a reset or pause; edge resets wait two clocks, level-reset release and pause restart at once.
                if (restart_q == 2'h0 && runEff && !levelReset && (mEdgeRst || mLimit))
                begin
                    state_d = hlt_pkg::ST_RUN;
                    pwm_d = 1'b1; // [R6] [R18]
                end
                else if (mLevel && runEff && !levelReset)
                begin
                    state_d = hlt_pkg::ST_RUN; // [R9]
                end
                else if ((freeRun && !mLevel && !mEdgeRst) && runEff)
                    state_d = hlt_pkg::ST_RUN; // [R12]
                else if (!runEff && (mOneEdge || mLimit))
                    state_d = hlt_pkg::ST_IDLE; // [R15]
            end
            default:
                state_d = hlt_pkg::ST_IDLE;
        endcase
        // A new mode starts from idle, so a paused state of the old mode cannot start it without its trigger.
        if (wrCtrl && apbReq.pwdata[hlt_pkg::CTRL_MODE_LSB +: 5] != mode_q)
            state_d = hlt_pkg::ST_IDLE; // [R14] [R17]
        // Software writes take priority in the same cycle, except hardware clearing run wins.
        if (wrCount)
            count_d = apbReq.pwdata[7:0]; // [R22]
        if (wrCtrl)
            run_d = apbReq.pwdata[hlt_pkg::CTRL_RUN_BIT] && run_d;
        if (wrCtrl && !(run_q && !run_d))
            run_d = apbReq.pwdata[hlt_pkg::CTRL_RUN_BIT];
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            count_q <= hlt_pkg::COUNT_RESET; // [R22]
            period_q <= hlt_pkg::PERIOD_RESET;
            width_q <= hlt_pkg::WIDTH_RESET;
            mode_q <= hlt_pkg::MODE_RESET;
            run_q <= 1'b0;
            runDelay_q <= 1'b0;
            extPrev_q <= 1'b0;
            pwm_q <= 1'b0;
            restart_q <= 2'h0;
            state_q <= hlt_pkg::ST_IDLE;
            periodMatch_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            run_q <= run_d;
            runDelay_q <= run_q; // [R21]
            extPrev_q <= extSync;
            pwm_q <= pwm_d;
            restart_q <= restart_d;
            state_q <= state_d;
            periodMatch_q <= state_q == hlt_pkg::ST_RUN && runEff && gateOpen && atPeriod;
            if (apbWrite && hitPeriod)
                period_q <= apbReq.pwdata[7:0];
            if (apbWrite && hitWidth)
                width_q <= apbReq.pwdata[7:0];
            if (wrCtrl)
                mode_q <= apbReq.pwdata[hlt_pkg::CTRL_MODE_LSB +: 5];
        end
    end

    // APB answer: pready rises in the access phase, one wait state.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= apbAccess && !pready_q;
            prdata_q <= (apbAccess && !pready_q && !apbReq.pwrite) ? readMux : 32'h0000_0000;
            pslverr_q <= apbAccess && !pready_q && !hitAny;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign countValue = count_q;
    assign periodMatch = periodMatch_q;
    assign pwmOut = pwm_q;
endmodule : hlt_timer
`default_nettype wire

// file: common/hlt_pkg.sv
// Functional notes
// R1 - Mode 00000: count while run bit set.
// R2 - Period match returns count to zero next.
// R3 - Modes 00001/00010 halt on high/low input.
// R4 - Halts stretch PWM period and high time.
// R5 - Modes 00011/00100/00101: edge clears counter early.
// R6 - Early edge reset restarts PWM after two clocks.
// R7 - Modes 00110/00111: held reset at low/high level.
// R8 - Run bit clear: level reset ignored.
// R9 - Level reset acts and releases after two clocks; the code returns to counting at once on release, with no restart delay.
// R10 - Level mode: PWM stays high through reset.
// R11 - Mode 01000: period match clears run bit.
// R12 - Software one-shot: clearing run bit pauses counting.
// R13 - Software one-shot PWM starts with run bit.
// R14 - Modes 01001/01010/01011: edge starts one-shot.
// R15 - Edge one-shot halted needs new edge.
// R16 - Edge one-shot PWM on at edge, off at match.
// R17 - Modes 01100/01101: first edge starts, later edges reset.
// R18 - Edge-limit restart two clocks after reset edge.
// R19 - Edge-limit match clears run; edges then ignored.
// R20 - Edge-limit start and reset edges drive PWM.
// R21 - Run bit and input pass a synchroniser.
// R22 - Eight-bit counter, software access, resets to zero.
// R23 - Edges found from successive synchronised samples.
package hlt_pkg;
    localparam logic [31:0] ADDR_COUNT = 32'h0000_0000;
    localparam logic [31:0] ADDR_PERIOD = 32'h0000_0004;
    localparam logic [31:0] ADDR_WIDTH = 32'h0000_0008;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_000C;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MODE_LSB = 8;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [7:0] WIDTH_RESET = 8'h00;
    localparam logic [4:0] MODE_RESET = 5'h00;
    localparam logic [1:0] RESTART_DELAY = 2'h2;

    typedef enum logic [4:0] {
        MODE_SW_GATE = 5'h00,
        MODE_GATE_HIGH_STOP = 5'h01,
        MODE_GATE_LOW_STOP = 5'h02,
        MODE_EDGE_RST_ANY = 5'h03,
        MODE_EDGE_RST_RISE = 5'h04,
        MODE_EDGE_RST_FALL = 5'h05,
        MODE_LEVEL_RST_LOW = 5'h06,
        MODE_LEVEL_RST_HIGH = 5'h07,
        MODE_ONESHOT_SW = 5'h08,
        MODE_ONESHOT_RISE = 5'h09,
        MODE_ONESHOT_FALL = 5'h0A,
        MODE_ONESHOT_ANY = 5'h0B,
        MODE_LIMIT_ONESHOT_RISE = 5'h0C,
        MODE_LIMIT_ONESHOT_FALL = 5'h0D
    } hlt_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b100
    } hlt_state_e;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } hlt_apb_req_s;
endpackage : hlt_pkg

// file: design/hlt_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a change is taken once stages two and three agree.
module hlt_sync (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic asyncIn,
    output logic syncOut
);
    logic [2:0] stage_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            stage_q <= 3'h0;
        else
            stage_q <= {stage_q[1:0], asyncIn};
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            syncOut <= 1'b0;
        else if (stage_q[1] == stage_q[2])
            syncOut <= stage_q[2];
    end
endmodule : hlt_sync
`default_nettype wire

// file: bench/hlt_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hlt_timer_sva (
    input wire logic core_clk,
    input wire logic srst,
    input wire hlt_pkg::hlt_apb_req_s apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic extResetInput,
    input wire logic [7:0] countValue,
    input wire logic periodMatch,
    input wire logic pwmOut
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    wire mapped = apbReq.paddr <= hlt_pkg::ADDR_STATUS && apbReq.paddr[1:0] == 2'h0;
    logic cntWr_q;
    // A software write to the counter may move it anywhere, so that step is exempt below.
    always_ff @(posedge core_clk)
    begin
        cntWr_q <= pready && apbReq.pwrite && apbReq.paddr == hlt_pkg::ADDR_COUNT;
    end
    sequence access_start;
        apbReq.psel && apbReq.penable && !$past(apbReq.penable);
    endsequence
    pready_wait_a: assert property (access_start |=> pready) else $error("late ready");
    pready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    pready_sel_a: assert property (pready |-> apbReq.psel && apbReq.penable) else $error("stray ready");
    slverr_map_a: assert property (pready |-> pslverr == !mapped) else $error("bad error flag");
    refused_zero_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("refused data");
    reset_clear_a: assert property (disable iff (1'b0) srst |=> countValue == 8'h00 && !pwmOut && !periodMatch)
        else $error("reset state");
    count_step_a: assert property (countValue != $past(countValue) && !cntWr_q
        |-> countValue == $past(countValue) + 8'h01 || countValue == 8'h00) else $error("count jump");
    match_zero_a: assert property (periodMatch |-> countValue == 8'h00 || $past(countValue) == 8'h00)
        else $error("match without wrap");
endmodule : hlt_timer_sva
bind hlt_timer hlt_timer_sva hlt_timer_sva_i (.core_clk(core_clk), .srst(srst), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extResetInput(extResetInput), .countValue(countValue),
    .periodMatch(periodMatch), .pwmOut(pwmOut));
`default_nettype wire

// file: bench/hlt_ext_source.sv
`timescale 1ns/1ps
`default_nettype none
module hlt_ext_source (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic wantHigh,
    output logic extLevel
);
    // A clean registered level; any synchronising is the timer's own job.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            extLevel <= 1'b0;
        else
            extLevel <= wantHigh;
    end
endmodule : hlt_ext_source
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk;
    logic srst;
    logic wantHigh;
    logic extLevel;
    hlt_pkg::hlt_apb_req_s req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] countValue;
    logic periodMatch;
    logic pwmOut;
    int mismatches;
    int checked;
    logic [7:0] held;
    hlt_timer hlt_timer_i (.core_clk(core_clk), .srst(srst), .apbReq(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extResetInput(extLevel), .countValue(countValue), .periodMatch(periodMatch),
        .pwmOut(pwmOut));
    hlt_ext_source hlt_ext_source_i (.core_clk(core_clk), .srst(srst), .wantHigh(wantHigh), .extLevel(extLevel));
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task complete_run;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // The task releases the bus for one cycle so that back-to-back calls never drive psel twice in a step.
    task apb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge core_clk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20)
            chk(32'h0, 32'h1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, expErr});
    endtask : rd
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task stop_at(input logic [7:0] p);
        wr(hlt_pkg::ADDR_CTRL, 32'h0);
        wr(hlt_pkg::ADDR_COUNT, 32'h0);
        wr(hlt_pkg::ADDR_PERIOD, {24'h0, p});
    endtask : stop_at
    task start(input hlt_pkg::hlt_mode_e m);
        wr(hlt_pkg::ADDR_CTRL, {19'h0, m, 8'h01});
    endtask : start
    task wait_count(input logic [7:0] v);
        int n;
        n = 0;
        while (countValue !== v && n < 600)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(countValue, v);
    endtask : wait_count
    task test_reset_map;
        rd(hlt_pkg::ADDR_COUNT, 32'h0, 1'b0);
        rd(hlt_pkg::ADDR_PERIOD, 32'hFF, 1'b0);
        rd(hlt_pkg::ADDR_CTRL, 32'h0, 1'b0);
        rd(32'h0000_0040, 32'h0, 1'b1);
        wr(hlt_pkg::ADDR_COUNT, 32'h0000_00A5);
        rd(hlt_pkg::ADDR_COUNT, 32'hA5, 1'b0);
    endtask : test_reset_map
    task test_sw_gate;
        stop_at(8'h05);
        start(hlt_pkg::MODE_SW_GATE);
        wait_count(8'h05);
        cyc(1);
        chk(countValue, 8'h00);
        cyc(1);
        chk(countValue, 8'h01);
        wr(hlt_pkg::ADDR_CTRL, 32'h0);
        cyc(3);
        held = countValue;
        cyc(6);
        chk(countValue, held);
    endtask : test_sw_gate
    task test_gate_high;
        stop_at(8'hFF);
        wantHigh <= 1'b1;
        start(hlt_pkg::MODE_GATE_HIGH_STOP);
        cyc(8);
        held = countValue;
        cyc(6);
        chk(countValue, held);
        wantHigh <= 1'b0;
        cyc(10);
        chk({31'h0, countValue > held}, 32'h1);
    endtask : test_gate_high
    task test_edge_reset;
        stop_at(8'hFF);
        start(hlt_pkg::MODE_EDGE_RST_RISE);
        wait_count(8'd40);
        wantHigh <= 1'b1;
        cyc(12);
        chk({31'h0, countValue < 8'd12}, 32'h1);
    endtask : test_edge_reset
    task test_level_reset;
        stop_at(8'hFF);
        start(hlt_pkg::MODE_LEVEL_RST_HIGH);
        cyc(10);
        chk(countValue, 8'h00);
        wantHigh <= 1'b0;
        cyc(12);
        chk({31'h0, countValue != 8'h00}, 32'h1);
    endtask : test_level_reset
    task test_one_shot;
        int n;
        stop_at(8'h05);
        start(hlt_pkg::MODE_ONESHOT_SW);
        n = 0;
        while (periodMatch !== 1'b1 && n < 60)
        begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, periodMatch}, 32'h1);
        cyc(3);
        rd(hlt_pkg::ADDR_CTRL, 32'h0000_0800, 1'b0);
        cyc(5);
        chk(countValue, 8'h00);
        chk({31'h0, pwmOut}, 32'h0);
    endtask : test_one_shot
    task test_edge_start;
        stop_at(8'hFF);
        start(hlt_pkg::MODE_ONESHOT_RISE);
        cyc(10);
        chk(countValue, 8'h00);
        wantHigh <= 1'b1;
        cyc(12);
        chk({31'h0, countValue != 8'h00}, 32'h1);
    endtask : test_edge_start
    // A start edge, a later reset edge with its own restart, then the period match ends the shot.
    task test_edge_limit;
        stop_at(8'hFF);
        wantHigh <= 1'b0;
        start(hlt_pkg::MODE_LIMIT_ONESHOT_RISE);
        cyc(10);
        chk(countValue, 8'h00);
        wantHigh <= 1'b1;
        wait_count(8'd30);
        wantHigh <= 1'b0;
        cyc(10);
        wantHigh <= 1'b1;
        cyc(14);
        chk({31'h0, countValue != 8'h00 && countValue < 8'd12}, 32'h1);
        wait_count(8'hFF);
        cyc(4);
        rd(hlt_pkg::ADDR_CTRL, 32'h0000_0C00, 1'b0);
        wantHigh <= 1'b0;
        cyc(8);
        wantHigh <= 1'b1;
        cyc(12);
        chk(countValue, 8'h00);
    endtask : test_edge_limit
    initial
    begin
        mismatches = 0;
        checked = 0;
        wantHigh = 1'b0;
        req = '0;
        srst = 1'b1;
        cyc(3);
        srst <= 1'b0;
        cyc(1);
        test_reset_map();
        test_sw_gate();
        test_gate_high();
        test_edge_reset();
        test_level_reset();
        test_one_shot();
        test_edge_start();
        test_edge_limit();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
